// ===== pkg/pll_detector_pkg.sv
// Shared constants for the phase detector trio.
// Assumes a single 25 MHz clock domain; no registers reachable by software.
package pll_detector_pkg;
	localparam int          CLOCK_HZ        = 25000000;
	localparam int          SYNC_STAGES     = 3;
	// Oscillator half period in clock cycles (even duty cycle by construction)
	localparam logic [15:0] OSC_HALF_MIN    = 16'h0002;
	localparam logic [15:0] OSC_HALF_MAX    = 16'h0400;
	localparam int          CTRL_WIDTH      = 8;
	// Detector selection codes
	localparam logic [1:0]  SEL_XOR         = 2'h0;
	localparam logic [1:0]  SEL_PFD         = 2'h1;
	localparam logic [1:0]  SEL_SETRESET    = 2'h2;
	// Pump state of the edge phase-frequency detector
	typedef enum logic [1:0] {PUMP_OFF, PUMP_UP, PUMP_DOWN} pump_t;
endpackage

// ===== hdl/pin_sync.sv
// Three-stage synchroniser for one asynchronous pin with rising-edge output.
// Assumes the pin is slower than half the clock rate.
`timescale 1ns/1ps
module pin_sync (
	input  wire logic clock,     // System clock
	input  wire logic reset,     // Synchronous reset, active high
	input  wire logic pinIn,     // Asynchronous pin
	output logic      level,     // Settled level
	output logic      rise       // One-cycle pulse on settled rising edge
);
	logic [2:0] stage_r;
	logic       level_r;

	always_ff @(posedge clock) begin
		if (reset) begin
			stage_r <= 3'h0;
		end else begin
			stage_r <= {stage_r[1:0], pinIn};
		end
	end

	// Change accepted once second and third stages agree
	always_ff @(posedge clock) begin
		if (reset) begin
			level_r <= 1'b0;
		end else if (stage_r[1] == stage_r[2]) begin
			level_r <= stage_r[2];
		end
	end

	assign level = level_r;
	assign rise  = (stage_r[1] == stage_r[2]) && stage_r[2] && !level_r;
endmodule

// ===== hdl/pll_phase_detector_trio.sv
// Phase comparison logic of a PLL: XOR, edge phase-frequency, set/reset detectors,
// plus a digital oscillator whose frequency follows the selected detector output.
// Assumes reference and feedback are asynchronous pins; feedback is wired back
// from oscillatorOutput directly or through an external divider.
// Contract
// - XOR output is high whenever reference and feedback differ.
// - Edge detector acts only on rising edges; duty cycles irrelevant.
// - Two flip-flops with gating form up/down counter driving three-state output.
// - Equal frequency: drive high while reference leads, low while lagging.
// - Reference faster: mostly high, otherwise high impedance.
// - Reference slower: output driven low most of each cycle.
// - Locked: output high impedance and lock indicator stays high.
// - No reference edges: edge detector pulls oscillator to lowest frequency.
// - Third detector is a set/reset flip-flop on rising edges only.
// - Third detector spans zero to full period, mid-scale at half period.
// - Locked at centre, feedback lags reference by half a period.
// - No reference edges: set/reset detector steers oscillator lowest.
// - Disable low enables oscillator and demodulator; high turns both off.
// - Steady control gives oscillator output an even duty cycle.
`timescale 1ns/1ps
module pll_phase_detector_trio #(
	parameter int CTRL_W = pll_detector_pkg::CTRL_WIDTH
) (
	input  wire logic              clock,                    // 25 MHz system clock
	input  wire logic              reset,                    // Synchronous reset, active high
	input  wire logic              referenceInput,           // Reference pin
	input  wire logic              feedbackInput,            // Feedback pin
	input  wire logic              oscillatorDisable,        // High turns oscillator off
	input  wire logic [1:0]        detectorSelect,           // Detector steering oscillator
	output logic                   xorDetectorOutput,        // XOR detector output
	output logic                   pfdTristateOutput,        // Edge detector output level
	output logic                   pfdTristateOutputEnable,  // High while a driver is on
	output logic                   setresetDetectorOutput,   // Set/reset detector output
	output logic                   lockIndicatorOutput,      // High while both drivers off
	output logic                   oscillatorOutput,         // Oscillator output
	output logic [CTRL_W-1:0]      demodulatorOutput         // Copy of oscillator control
);
	logic                  refLevel;
	logic                  refRise;
	logic                  fbLevel;
	logic                  fbRise;
	logic                  xor_r;
	logic                  upFlop_r;
	logic                  downFlop_r;
	logic                  setReset_r;
	logic [CTRL_W-1:0]     control_r;
	logic [15:0]           oscCount_r;
	logic                  osc_r;
	logic [CTRL_W-1:0]     demod_r;
	logic                  pfdLevel_r;
	logic                  pfdEnable_r;
	logic                  lock_r;
	logic                  upNow;
	logic                  downNow;
	logic [15:0]           halfPeriod;
	logic                  halfDone;

	pin_sync refSync (
		.clock  (clock),
		.reset  (reset),
		.pinIn  (referenceInput),
		.level  (refLevel),
		.rise   (refRise)
	);

	pin_sync fbSync (
		.clock  (clock),
		.reset  (reset),
		.pinIn  (feedbackInput),
		.level  (fbLevel),
		.rise   (fbRise)
	);

	// Maps a control code to a half period: larger code, shorter period
	function automatic logic [15:0] half_period(input logic [CTRL_W-1:0] code);
		logic [31:0] span;
		logic [31:0] step;
		span = 32'(pll_detector_pkg::OSC_HALF_MAX - pll_detector_pkg::OSC_HALF_MIN);
		step = (span * 32'(code)) >> CTRL_W;
		half_period = 16'(32'(pll_detector_pkg::OSC_HALF_MAX) - step);
	endfunction

	always_ff @(posedge clock) begin
		if (reset) begin
			xor_r <= 1'b0;
		end else begin
			xor_r <= refLevel ^ fbLevel;
		end
	end

	// Up flop: set by a reference rise, cleared once a feedback rise arrives
	always_ff @(posedge clock) begin
		if (reset) begin
			upFlop_r <= 1'b0;
		end else begin
			upFlop_r <= (upFlop_r | refRise) & ~(downFlop_r | fbRise);
		end
	end

	// Down flop: mirror image, so a pair of opposite rises clears both
	always_ff @(posedge clock) begin
		if (reset) begin
			downFlop_r <= 1'b0;
		end else begin
			downFlop_r <= (downFlop_r | fbRise) & ~(upFlop_r | refRise);
		end
	end

	assign upNow   = upFlop_r & ~downFlop_r;
	assign downNow = downFlop_r & ~upFlop_r;

	// Level: high while an up count is pending, low otherwise
	always_ff @(posedge clock) begin
		if (reset) begin
			pfdLevel_r <= 1'b0;
		end else begin
			pfdLevel_r <= upNow;
		end
	end

	// Either driver on takes the output out of high impedance
	always_ff @(posedge clock) begin
		if (reset) begin
			pfdEnable_r <= 1'b0;
		end else begin
			pfdEnable_r <= upNow | downNow;
		end
	end

	// Lock indicator is the inverse of the drive, in the same cycle
	always_ff @(posedge clock) begin
		if (reset) begin
			lock_r <= 1'b1;
		end else begin
			lock_r <= ~(upNow | downNow);
		end
	end

	// Set by reference, reset by feedback; simultaneous edges keep state
	always_ff @(posedge clock) begin
		if (reset) begin
			setReset_r <= 1'b0;
		end else if (refRise && !fbRise) begin
			setReset_r <= 1'b1;
		end else if (fbRise && !refRise) begin
			setReset_r <= 1'b0;
		end
	end

	// Loop integrator: selected detector nudges the control word each cycle
	always_ff @(posedge clock) begin
		if (reset) begin
			control_r <= '0;
		end else begin
			case (detectorSelect)
				pll_detector_pkg::SEL_XOR: begin
					if (xor_r && control_r != '1) begin
						control_r <= control_r + 1'b1;
					end else if (!xor_r && control_r != '0) begin
						control_r <= control_r - 1'b1;
					end
				end
				pll_detector_pkg::SEL_PFD: begin
					if (upNow && control_r != '1) begin
						control_r <= control_r + 1'b1;
					end else if (downNow && control_r != '0) begin
						control_r <= control_r - 1'b1;
					end
				end
				pll_detector_pkg::SEL_SETRESET: begin
					// Balanced at half-period lag, where set and reset times match
					if (setReset_r && control_r != '1) begin
						control_r <= control_r + 1'b1;
					end else if (!setReset_r && control_r != '0) begin
						control_r <= control_r - 1'b1;
					end
				end
				default: begin
					control_r <= control_r;
				end
			endcase
		end
	end

	assign halfPeriod = half_period(control_r);
	assign halfDone   = (oscCount_r + 16'h0001) >= halfPeriod;

	// Counter restarts at each toggle and stays cleared while the oscillator is off
	always_ff @(posedge clock) begin
		if (reset || oscillatorDisable) begin
			oscCount_r <= 16'h0000;
		end else if (halfDone) begin
			oscCount_r <= 16'h0000;
		end else begin
			oscCount_r <= oscCount_r + 16'h0001;
		end
	end

	// Equal high and low halves give an even duty cycle
	always_ff @(posedge clock) begin
		if (reset || oscillatorDisable) begin
			osc_r <= 1'b0;
		end else if (halfDone) begin
			osc_r <= ~osc_r;
		end
	end

	always_ff @(posedge clock) begin
		if (reset || oscillatorDisable) begin
			demod_r <= '0;
		end else begin
			demod_r <= control_r;
		end
	end

	assign xorDetectorOutput       = xor_r;
	assign pfdTristateOutput       = pfdLevel_r;
	assign pfdTristateOutputEnable = pfdEnable_r;
	assign setresetDetectorOutput  = setReset_r;
	assign lockIndicatorOutput     = lock_r;
	assign oscillatorOutput        = osc_r;
	assign demodulatorOutput       = demod_r;
endmodule

// ===== test/pll_phase_detector_trio_assertions.sv
// Port-level checker for the phase detector trio.
// Assumes pins change only at clock edges; bound to the top module below.
`timescale 1ns/1ps
module pll_phase_detector_trio_checker #(
	parameter int CTRL_W = 8
) (
	input wire logic              clock,                   // Clock
	input wire logic              reset,                   // Reset
	input wire logic              referenceInput,          // Pin
	input wire logic              feedbackInput,           // Pin
	input wire logic              oscillatorDisable,       // Off
	input wire logic [1:0]        detectorSelect,          // Select
	input wire logic              xorDetectorOutput,       // Out
	input wire logic              pfdTristateOutput,       // Level
	input wire logic              pfdTristateOutputEnable, // Drive
	input wire logic              setresetDetectorOutput,  // Out
	input wire logic              lockIndicatorOutput,     // Lock
	input wire logic              oscillatorOutput,        // Osc
	input wire logic [CTRL_W-1:0] demodulatorOutput        // Control
);
	default clocking @(posedge clock); endclocking
	default disable iff (reset);
	sequence quietPins;
		($stable(referenceInput) && $stable(feedbackInput))[*6];
	endsequence
	AST_LOCK_INV: assert property (lockIndicatorOutput != pfdTristateOutputEnable)
		else $error("lock not inverse of drive");
	AST_XOR: assert property (quietPins |-> xorDetectorOutput == (referenceInput ^ feedbackInput))
		else $error("xor output wrong");
	AST_SR_SET: assert property ($rose(referenceInput) && !$rose(feedbackInput) ##1 quietPins |-> setresetDetectorOutput)
		else $error("set missed");
	AST_SR_CLR: assert property ($rose(feedbackInput) && !$rose(referenceInput) ##1 quietPins |-> !setresetDetectorOutput)
		else $error("clear missed");
	AST_PFD_HOLD: assert property (quietPins ##0 pfdTristateOutputEnable |=> pfdTristateOutputEnable && $stable(pfdTristateOutput))
		else $error("drive dropped");
	AST_PFD_OFF: assert property (quietPins ##0 !pfdTristateOutputEnable |=> !pfdTristateOutputEnable)
		else $error("drive without edge");
	AST_OSC_DISABLED: assert property (oscillatorDisable[*2] |-> demodulatorOutput == 0 && !oscillatorOutput)
		else $error("disable ignored");
	AST_OSC_HI: assert property ($rose(oscillatorOutput) && !oscillatorDisable |=> oscillatorOutput)
		else $error("high half too short");
	AST_OSC_LO: assert property ($fell(oscillatorOutput) |=> !oscillatorOutput)
		else $error("low half too short");
	AST_PFD_DOWN: assert property ((!referenceInput && !oscillatorDisable && detectorSelect == 2'h1 && !(pfdTristateOutputEnable && pfdTristateOutput))[*4] |-> demodulatorOutput <= $past(demodulatorOutput))
		else $error("control rose without reference");
	cover property ($rose(pfdTristateOutputEnable) && !pfdTristateOutput);
	cover property ($rose(setresetDetectorOutput));
	cover property (oscillatorDisable && demodulatorOutput != 0);
endmodule
bind pll_phase_detector_trio pll_phase_detector_trio_checker #(.CTRL_W(CTRL_W)) checker_i (
	.clock                   (clock),
	.reset                   (reset),
	.referenceInput          (referenceInput),
	.feedbackInput           (feedbackInput),
	.oscillatorDisable       (oscillatorDisable),
	.detectorSelect          (detectorSelect),
	.xorDetectorOutput       (xorDetectorOutput),
	.pfdTristateOutput       (pfdTristateOutput),
	.pfdTristateOutputEnable (pfdTristateOutputEnable),
	.setresetDetectorOutput  (setresetDetectorOutput),
	.lockIndicatorOutput     (lockIndicatorOutput),
	.oscillatorOutput        (oscillatorOutput),
	.demodulatorOutput       (demodulatorOutput)
);

// ===== test/loop_partner.sv
// Far side of the loop: divider from oscillator back to the feedback pin.
// Assumes the bench drives the feedback level itself while the loop is open.
`timescale 1ns/1ps
module loop_partner #(
	parameter int DIV = 1
) (
	input  wire logic clock,            // Clock
	input  wire logic reset,            // Reset
	input  wire logic oscillatorOutput, // Oscillator
	input  wire logic closeLoop,        // High feeds oscillator back
	input  wire logic benchFeedback,    // Open-loop level
	output logic      feedbackInput     // To feedback pin
);
	int   count;
	logic oscLast, divOut;
	// Toggles once per DIV oscillator transitions, keeping an even duty
	always_ff @(posedge clock) begin
		oscLast <= oscillatorOutput;
		if (reset) begin
			count <= 0;
			divOut <= 1'b0;
		end else if (oscillatorOutput != oscLast) begin
			count <= (count + 1 == DIV) ? 0 : count + 1;
			if (count + 1 == DIV) begin
				divOut <= ~divOut;
			end
		end
	end
	assign feedbackInput = closeLoop ? divOut : benchFeedback;
endmodule

// ===== test/pll_phase_detector_trio_tb.sv
// Self-checking bench for the phase detector trio.
// Assumes the partner closes the loop on request; pins move on clock edges.
`timescale 1ns/1ps
module pll_phase_detector_trio_tb;
	logic       clock, reset, refPin, fbSet, fbPin, closeLoop, oscDis;
	logic       xorOut, pfdLvl, pfdEn, srOut, lock, oscOut;
	logic [1:0] sel;
	logic [7:0] demod;
	int         fails = 0, checksDone = 0, cycles = 0, hi, lo;
	// Steps of {reference, feedback, drive, level, set/reset}; tail repeats one side's edges
	logic [4:0] steps [18] = '{5'h17, 5'h18, 5'h00, 5'h0c, 5'h19, 5'h01, 5'h19, 5'h01,
		5'h17, 5'h07, 5'h17, 5'h18, 5'h00, 5'h0c, 5'h04, 5'h0c, 5'h19, 5'h01};
	pll_phase_detector_trio pll_phase_detector_trio_i (.clock(clock), .reset(reset),
		.referenceInput(refPin), .feedbackInput(fbPin), .oscillatorDisable(oscDis),
		.detectorSelect(sel), .xorDetectorOutput(xorOut), .pfdTristateOutput(pfdLvl),
		.pfdTristateOutputEnable(pfdEn), .setresetDetectorOutput(srOut),
		.lockIndicatorOutput(lock), .oscillatorOutput(oscOut), .demodulatorOutput(demod));
	loop_partner loop_partner_i (.clock(clock), .reset(reset), .oscillatorOutput(oscOut),
		.closeLoop(closeLoop), .benchFeedback(fbSet), .feedbackInput(fbPin));
	function automatic logic xorExp(input logic a, input logic b);
		return a ^ b;
	endfunction
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		checksDone++;
		if (seen !== exp) begin
			fails++;
			$display("FAIL %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic finalReport;
		if (fails == 0 && checksDone > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask
	task automatic pins(input logic r, input logic f, input int n);
		@(posedge clock);
		refPin <= r;
		fbSet <= f;
		repeat (n) @(posedge clock);
		#1;
	endtask
	task automatic mode(input logic [1:0] s, input logic c, input logic d);
		@(posedge clock);
		sel <= s;
		closeLoop <= c;
		oscDis <= d;
	endtask
	task automatic runLen(input logic lvl, output int n);
		n = 0;
		while (oscOut === lvl && n < 3000) begin
			@(posedge clock);
			#1;
			n++;
		end
	endtask
	initial begin
		clock = 0;
		forever #20 clock = ~clock;
	end
	always @(posedge clock) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			fails++;
			finalReport();
		end
	end
	initial begin
		{reset, refPin, fbSet, closeLoop, oscDis, sel} = 7'h43;
		void'($urandom(40));
		repeat (2) @(posedge clock);
		reset <= 1'b0;
		#1;
		check(lock, 1'b1);
		runLen(1'b0, lo);
		runLen(1'b1, hi);
		runLen(1'b0, lo);
		check(16'(hi), pll_detector_pkg::OSC_HALF_MAX);
		check(16'(lo), pll_detector_pkg::OSC_HALF_MAX);
		for (int i = 0; i < 18; i++) begin
			pins(steps[i][4], steps[i][3], 8);
			check(pfdEn, steps[i][2]);
			check(lock, !steps[i][2]);
			check(srOut, steps[i][0]);
			if (steps[i][2]) check(pfdLvl, steps[i][1]);
		end
		for (int i = 0; i < 24; i++) begin
			pins(1'($urandom), 1'($urandom), 6 + $urandom % 4);
			check(xorOut, xorExp(refPin, fbSet));
		end
		mode(pll_detector_pkg::SEL_XOR, 1'b0, 1'b0);
		pins(1'b1, 1'b0, 60);
		check(demod != 0, 1'b1);
		mode(pll_detector_pkg::SEL_XOR, 1'b0, 1'b1);
		pins(1'b1, 1'b0, 3);
		check({demod, oscOut}, 9'h000);
		mode(pll_detector_pkg::SEL_SETRESET, 1'b1, 1'b0);
		pins(1'b0, 1'b0, 4000);
		check(demod, 8'h00);
		mode(pll_detector_pkg::SEL_XOR, 1'b0, 1'b0);
		pins(1'b1, 1'b0, 60);
		mode(pll_detector_pkg::SEL_PFD, 1'b1, 1'b0);
		pins(1'b0, 1'b0, 4000);
		check({demod, pfdEn, pfdLvl}, 10'h002);
		finalReport();
	end
endmodule
